/* File: pkg/mfl_pkg.sv */
// constants, register codes and states for the global command register bank
package mfl_pkg;
   // command byte layout
   localparam int CMD_RW_BIT = 7;
   localparam logic [6:0] REG_RES_LOW = 7'h30;
   localparam logic [6:0] REG_RES_HIGH = 7'h31;
   localparam logic [6:0] REG_METER_WINDOW = 7'h32;
   localparam logic [6:0] REG_METER_SEL = 7'h33;
   localparam logic [6:0] REG_GAP_COUNT = 7'h34;
   localparam logic [6:0] REG_BYTE_COUNT = 7'h35;
   localparam logic [6:0] REG_SEIZE_COUNT = 7'h36;
   localparam logic [6:0] REG_MARK_COUNT = 7'h37;
   localparam logic [6:0] REG_SEND_CTRL = 7'h38;
   localparam logic [6:0] REG_LOOP_PD = 7'h3C;
   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // meter select register fields
   localparam int MSEL_CH_LSB = 0;
   localparam int MSEL_MODE = 3;
   localparam int MSEL_ON = 4;
   localparam int MSEL_TF = 5;
   localparam int MSEL_TOI = 6;
   localparam logic [7:0] MSEL_MASK = 8'h7F;
   // sender control register fields
   localparam int SCTL_START = 0;
   localparam int SCTL_MAS = 1;
   localparam int SCTL_VARIANT = 2;
   localparam int SCTL_CH_LSB = 4;
   localparam int SCTL_ON = 7;
   localparam logic [7:0] SCTL_MASK = 8'hF7;
   // loop register fields
   localparam int LOOP_PD = 6;
   localparam logic [7:0] LOOP_MASK = 8'h5F;
   // message limits
   localparam logic [7:0] MAX_BYTES = 8'h40;
   localparam logic [3:0] CHAR_BITS = 4'hA;
   // timing
   localparam int CLK_MHZ = 125;
   localparam int FRAME_US = 125;
   localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;
   localparam int BIT_NS = 833333;
   localparam int BIT_CYCLES = (BIT_NS * CLK_MHZ) / 1000;
   // sender states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SEIZE = 3'b001,
      ST_MARK = 3'b010,
      ST_DATA = 3'b011,
      ST_FLAG = 3'b100,
      ST_HOLD = 3'b101
   } mfl_state_t;
endpackage : mfl_pkg

/* File: src/mfl_regs.sv */
// global command registers with level meter and caller-id sender
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1: command byte: low seven bits code, top direction
// R2: zero window copies sample straight to results
// R3: window N accumulates over N frames
// R4: three-bit field picks metered channel ascending
// R5: mode clear passes compressed PCM to high
// R6: mode set meters linear, ready in low
// R7: meter runs only while its on bit set
// R8: teletax bit: clear 16 kHz, set 12 kHz
// R9: tone invert bit inverts dual tone output
// R10: gap count inserts ones between message bytes
// R11: byte count above 64 treated as 64
// R12: zero bytes still marks while mark-after-message set
// R13: seizure sends count pairs of zero-one bits
// R14: mark phase sends count one bits
// R15: software starts; hardware clears start at end
// R16: all counts zero clears start immediately
// R17: mark-after-message clear mutes after message
// R18: mark-after-message set keeps sending ones
// R19: variant bit selects regional signalling convention
// R20: sender channel pick; sender runs while on
// R21: five independent loopback enable bits
// R22: power-down bit stops synthesizer and clocks
// R23: reading high result clears ready bit
// R24: seizure, mark, bytes with gaps, then end
module mfl_regs #(
   parameter int FRAME_CYCLES = mfl_pkg::FRAME_CYCLES,
   parameter int BIT_CYCLES = mfl_pkg::BIT_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // command port
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_byte,
   input wire logic [7:0] cmd_wdata,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // pcm samples of all eight channels
   input wire logic [127:0] pcm_linear,
   input wire logic [63:0] pcm_comp,
   // message bytes for the sender
   input wire logic msg_valid,
   input wire logic [7:0] msg_data,
   output logic msg_ready,
   // sender output
   output logic send_bit,
   output logic send_bit_strobe,
   output logic send_mute,
   output logic [2:0] sender_channel_pick,
   output logic signalling_variant,
   // codec controls
   output logic teletax_freq_bit,
   output logic tone_invert,
   output logic [4:0] loopback_select,
   output logic synth_power_down
);
   localparam int FW = $clog2(FRAME_CYCLES + 1);
   localparam int BW = $clog2(BIT_CYCLES + 1);
   logic [7:0] meter_window_count, meter_sel, marker_gap_count, byte_cnt_reg;
   logic [7:0] seizure_pair_count, mark_bit_count, send_ctrl, loop_reg;
   logic [7:0] meter_result_high, meter_result_low, next_mem0, next_mem1;
   logic meter_ready_bit;
   logic [7:0] next_window, next_sel, next_gap, next_bytes, next_seize, next_mark;
   logic [7:0] next_ctrl, next_loop, next_rd_data, next_res_high, next_res_low;
   logic next_rd_valid, next_ready;
   logic wr_en, rd_en, hw_clear_start, high_read, frame_tick;
   logic [6:0] code;
   assign code = cmd_byte[6:0];
   assign wr_en = cmd_valid && !cmd_byte[mfl_pkg::CMD_RW_BIT];  // see R1
   assign rd_en = cmd_valid && cmd_byte[mfl_pkg::CMD_RW_BIT];  // see R1
   assign high_read = rd_en && (code == mfl_pkg::REG_RES_HIGH);
   // register writes and reads
   always_comb begin
      next_window = meter_window_count;
      next_sel = meter_sel;
      next_gap = marker_gap_count;
      next_bytes = byte_cnt_reg;
      next_seize = seizure_pair_count;
      next_mark = mark_bit_count;
      next_ctrl = send_ctrl;
      next_loop = loop_reg;
      if (hw_clear_start) begin
         next_ctrl[mfl_pkg::SCTL_START] = 1'b0;  // see R15
      end
      if (wr_en) begin
         unique case (code)
            mfl_pkg::REG_METER_WINDOW: next_window = cmd_wdata;
            mfl_pkg::REG_METER_SEL: next_sel = cmd_wdata & mfl_pkg::MSEL_MASK;
            mfl_pkg::REG_GAP_COUNT: next_gap = cmd_wdata;
            mfl_pkg::REG_BYTE_COUNT: next_bytes = cmd_wdata;
            mfl_pkg::REG_SEIZE_COUNT: next_seize = cmd_wdata;
            mfl_pkg::REG_MARK_COUNT: next_mark = cmd_wdata;
            // a start written in the clearing cycle wins
            mfl_pkg::REG_SEND_CTRL: next_ctrl = cmd_wdata & mfl_pkg::SCTL_MASK;
            mfl_pkg::REG_LOOP_PD: next_loop = cmd_wdata & mfl_pkg::LOOP_MASK;
            default: ;
         endcase
      end
      next_rd_valid = rd_en;
      next_rd_data = mfl_pkg::RESET_BYTE;
      if (rd_en) begin
         unique case (code)
            mfl_pkg::REG_RES_LOW: next_rd_data = {meter_result_low[7:1], meter_ready_bit};
            mfl_pkg::REG_RES_HIGH: next_rd_data = meter_result_high;
            mfl_pkg::REG_METER_WINDOW: next_rd_data = meter_window_count;
            mfl_pkg::REG_METER_SEL: next_rd_data = meter_sel;
            mfl_pkg::REG_GAP_COUNT: next_rd_data = marker_gap_count;
            mfl_pkg::REG_BYTE_COUNT: next_rd_data = byte_cnt_reg;
            mfl_pkg::REG_SEIZE_COUNT: next_rd_data = seizure_pair_count;
            mfl_pkg::REG_MARK_COUNT: next_rd_data = mark_bit_count;
            mfl_pkg::REG_SEND_CTRL: next_rd_data = send_ctrl;
            mfl_pkg::REG_LOOP_PD: next_rd_data = loop_reg;
            default: next_rd_data = mfl_pkg::RESET_BYTE;
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meter_window_count <= mfl_pkg::RESET_BYTE;  // see R2
         meter_sel <= mfl_pkg::RESET_BYTE;
         marker_gap_count <= mfl_pkg::RESET_BYTE;
         byte_cnt_reg <= mfl_pkg::RESET_BYTE;
         seizure_pair_count <= mfl_pkg::RESET_BYTE;
         mark_bit_count <= mfl_pkg::RESET_BYTE;
         send_ctrl <= mfl_pkg::RESET_BYTE;
         loop_reg <= mfl_pkg::RESET_BYTE;
         rd_data <= mfl_pkg::RESET_BYTE;
         rd_valid <= 1'b0;
      end else begin
         meter_window_count <= next_window;
         meter_sel <= next_sel;
         marker_gap_count <= next_gap;
         byte_cnt_reg <= next_bytes;
         seizure_pair_count <= next_seize;
         mark_bit_count <= next_mark;
         send_ctrl <= next_ctrl;
         loop_reg <= next_loop;
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
      end
   end
   assign teletax_freq_bit = meter_sel[mfl_pkg::MSEL_TF];  // see R8
   assign tone_invert = meter_sel[mfl_pkg::MSEL_TOI];  // see R9
   assign loopback_select = loop_reg[4:0];  // see R21
   assign synth_power_down = loop_reg[mfl_pkg::LOOP_PD];  // see R22
   assign signalling_variant = send_ctrl[mfl_pkg::SCTL_VARIANT];  // see R19
   assign sender_channel_pick = send_ctrl[mfl_pkg::SCTL_CH_LSB +: 3];  // see R20
   // frame tick divider, 8 kHz enable
   logic [FW-1:0] frame_cnt, next_frame_cnt;
   assign frame_tick = (frame_cnt == FW'(FRAME_CYCLES - 1));
   always_comb begin
      next_frame_cnt = frame_tick ? '0 : frame_cnt + FW'(1);
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         frame_cnt <= '0;
      end else begin
         frame_cnt <= next_frame_cnt;
      end
   end
   // level meter
   logic [15:0] lin_sample, lin_abs, peak, next_peak;
   logic [7:0] comp_sample, frames, next_frames;
   logic [2:0] meter_ch;
   assign meter_ch = meter_sel[mfl_pkg::MSEL_CH_LSB +: 3];
   assign lin_sample = pcm_linear[meter_ch*16 +: 16];  // see R4
   assign comp_sample = pcm_comp[meter_ch*8 +: 8];  // see R4
   assign lin_abs = lin_sample[15] ? 16'(~lin_sample + 16'h0001) : lin_sample;
   always_comb begin
      next_peak = peak;
      next_frames = frames;
      next_res_high = meter_result_high;
      next_res_low = meter_result_low;
      next_ready = meter_ready_bit && !high_read;  // see R23
      if (!meter_sel[mfl_pkg::MSEL_ON]) begin  // see R7
         next_peak = 16'h0000;
         next_frames = 8'h00;
      end else if (frame_tick) begin
         if (!meter_sel[mfl_pkg::MSEL_MODE]) begin
            next_res_high = comp_sample;  // see R5
         end else if (meter_window_count == 8'h00) begin
            next_res_high = lin_sample[15:8];  // see R2
            next_res_low = lin_sample[7:0];
            next_ready = 1'b1;  // see R6
         end else begin
            if (lin_abs > peak) begin
               next_peak = lin_abs;
            end
            next_frames = frames + 8'h01;
            if (next_frames >= meter_window_count) begin  // see R3
               next_res_high = next_peak[15:8];
               next_res_low = next_peak[7:0];
               next_ready = 1'b1;  // see R6
               next_peak = 16'h0000;
               next_frames = 8'h00;
            end
         end
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         peak <= 16'h0000;
         frames <= 8'h00;
         meter_result_high <= 8'h00;
         meter_result_low <= 8'h00;
         meter_ready_bit <= 1'b0;
      end else begin
         peak <= next_peak;
         frames <= next_frames;
         meter_result_high <= next_res_high;
         meter_result_low <= next_res_low;
         meter_ready_bit <= next_ready;
      end
   end
   // two-entry message buffer
   logic [7:0] buf_mem [2];
   logic [1:0] buf_cnt, next_buf_cnt;
   logic buf_wp, buf_rp, next_wp, next_rp, buf_pop, buf_push;
   assign msg_ready = (buf_cnt != 2'h2);
   assign buf_push = msg_valid && msg_ready;
   always_comb begin
      next_mem0 = (buf_push && !buf_wp) ? msg_data : buf_mem[0];
      next_mem1 = (buf_push && buf_wp) ? msg_data : buf_mem[1];
      next_wp = buf_wp ^ buf_push;
      next_rp = buf_rp ^ buf_pop;
      next_buf_cnt = 2'(buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop});
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         buf_mem[0] <= 8'h00;
         buf_mem[1] <= 8'h00;
         buf_cnt <= 2'd0;
         buf_wp <= 1'b0;
         buf_rp <= 1'b0;
      end else begin
         buf_mem[0] <= next_mem0;
         buf_mem[1] <= next_mem1;
         buf_cnt <= next_buf_cnt;
         buf_wp <= next_wp;
         buf_rp <= next_rp;
      end
   end
   // caller-id sender
   mfl_pkg::mfl_state_t state, next_state;
   logic [8:0] cnt, next_cnt;
   logic [3:0] bit_idx, next_bit_idx;
   logic [7:0] bytes_left, next_bytes_left, shreg, next_shreg, eff_bytes;
   logic [BW-1:0] bit_cnt, next_bit_cnt;
   logic bit_tick, next_send_bit, next_mute, start, mark_after_message;
   assign start = send_ctrl[mfl_pkg::SCTL_START];
   assign mark_after_message = send_ctrl[mfl_pkg::SCTL_MAS];
   assign bit_tick = (state != mfl_pkg::ST_IDLE) && (bit_cnt == BW'(BIT_CYCLES - 1));
   assign eff_bytes = (byte_cnt_reg > mfl_pkg::MAX_BYTES) ? mfl_pkg::MAX_BYTES
                                                          : byte_cnt_reg;  // see R11
   assign buf_pop = bit_tick && (state == mfl_pkg::ST_DATA) && (bit_idx == 4'd0)
                    && (buf_cnt != 2'd0);
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_bit_idx = bit_idx;
      next_bytes_left = bytes_left;
      next_shreg = shreg;
      next_send_bit = send_bit;
      next_mute = send_mute;
      next_bit_cnt = (state == mfl_pkg::ST_IDLE || bit_tick) ? '0 : bit_cnt + BW'(1);
      hw_clear_start = 1'b0;
      if (!send_ctrl[mfl_pkg::SCTL_ON]) begin  // see R20
         next_state = mfl_pkg::ST_IDLE;
         next_mute = 1'b1;
      end else begin
         unique case (state)
            mfl_pkg::ST_IDLE: begin
               next_mute = 1'b1;
               if (start) begin
                  next_bytes_left = eff_bytes;
                  next_bit_idx = 4'd0;
                  if (seizure_pair_count != 8'h00) begin  // see R24
                     next_state = mfl_pkg::ST_SEIZE;
                     next_cnt = {seizure_pair_count, 1'b0};  // see R13
                  end else if (mark_bit_count != 8'h00) begin
                     next_state = mfl_pkg::ST_MARK;
                     next_cnt = {1'b0, mark_bit_count};  // see R14
                  end else if (eff_bytes != 8'h00) begin
                     next_state = mfl_pkg::ST_DATA;
                  end else begin
                     hw_clear_start = 1'b1;  // see R16
                     next_state = mark_after_message ? mfl_pkg::ST_HOLD : mfl_pkg::ST_IDLE;  // see R12
                  end
               end
            end
            mfl_pkg::ST_SEIZE: if (bit_tick) begin
               next_mute = 1'b0;
               next_send_bit = cnt[0];  // see R13
               next_cnt = cnt - 9'd1;
               if (cnt == 9'd1) begin
                  if (mark_bit_count != 8'h00) begin
                     next_state = mfl_pkg::ST_MARK;
                     next_cnt = {1'b0, mark_bit_count};
                  end else if (bytes_left != 8'h00) begin
                     next_state = mfl_pkg::ST_DATA;
                  end else begin
                     hw_clear_start = 1'b1;  // see R15
                     next_state = mark_after_message ? mfl_pkg::ST_HOLD : mfl_pkg::ST_IDLE;
                  end
               end
            end
            mfl_pkg::ST_MARK: if (bit_tick) begin
               next_mute = 1'b0;
               next_send_bit = 1'b1;  // see R14
               next_cnt = cnt - 9'd1;
               if (cnt == 9'd1) begin
                  if (bytes_left != 8'h00) begin
                     next_state = mfl_pkg::ST_DATA;
                  end else begin
                     hw_clear_start = 1'b1;  // see R15
                     next_state = mark_after_message ? mfl_pkg::ST_HOLD : mfl_pkg::ST_IDLE;
                  end
               end
            end
            mfl_pkg::ST_DATA: if (bit_tick) begin
               next_mute = 1'b0;
               if (bit_idx == 4'd0) begin
                  // waits on marks while the buffer is empty
                  next_send_bit = (buf_cnt == 2'd0);
                  if (buf_cnt != 2'd0) begin
                     next_shreg = buf_mem[buf_rp];
                     next_bit_idx = 4'd1;
                  end
               end else if (bit_idx == mfl_pkg::CHAR_BITS - 4'd1) begin
                  next_send_bit = 1'b1;
                  next_bit_idx = 4'd0;
                  next_bytes_left = bytes_left - 8'h01;
                  if (bytes_left == 8'h01) begin
                     hw_clear_start = 1'b1;  // see R15
                     next_state = mark_after_message ? mfl_pkg::ST_HOLD : mfl_pkg::ST_IDLE;  // see R17
                  end else if (marker_gap_count != 8'h00) begin
                     next_state = mfl_pkg::ST_FLAG;
                     next_cnt = {1'b0, marker_gap_count};  // see R10
                  end
               end else begin
                  next_send_bit = shreg[0];
                  next_shreg = {1'b0, shreg[7:1]};
                  next_bit_idx = bit_idx + 4'd1;
               end
            end
            mfl_pkg::ST_FLAG: if (bit_tick) begin
               next_send_bit = 1'b1;  // see R10
               next_cnt = cnt - 9'd1;
               if (cnt == 9'd1) begin
                  next_state = mfl_pkg::ST_DATA;
               end
            end
            mfl_pkg::ST_HOLD: begin
               if (!mark_after_message) begin
                  next_state = mfl_pkg::ST_IDLE;  // see R18
                  next_mute = 1'b1;
               end else if (bit_tick) begin
                  next_mute = 1'b0;
                  next_send_bit = 1'b1;  // see R18
               end
            end
            default: next_state = mfl_pkg::ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state <= mfl_pkg::ST_IDLE;
         cnt <= 9'd0;
         bit_idx <= 4'd0;
         bytes_left <= 8'h00;
         shreg <= 8'h00;
         bit_cnt <= '0;
         send_bit <= 1'b1;
         send_mute <= 1'b1;
         send_bit_strobe <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         bit_idx <= next_bit_idx;
         bytes_left <= next_bytes_left;
         shreg <= next_shreg;
         bit_cnt <= next_bit_cnt;
         send_bit <= next_send_bit;
         send_mute <= next_mute;
         send_bit_strobe <= bit_tick && send_ctrl[mfl_pkg::SCTL_ON];
      end
   end
endmodule : mfl_regs
`default_nettype wire

/* File: tb/mfl_regs_assertions.sv */
// checker of command port and register output timing
`timescale 1ns/10ps
`default_nettype none
module mfl_regs_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // command port
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_byte,
   input wire logic [7:0] cmd_wdata,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   // outputs
   input wire logic send_bit_strobe,
   input wire logic [2:0] sender_channel_pick,
   input wire logic signalling_variant,
   input wire logic teletax_freq_bit,
   input wire logic tone_invert,
   input wire logic [4:0] loopback_select,
   input wire logic synth_power_down
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire logic rd_cmd = cmd_valid & cmd_byte[7];
   wire logic wr_cmd = cmd_valid & ~cmd_byte[7];
   wire logic [6:0] code = cmd_byte[6:0];
   wire logic unmapped = code < 7'h30 || code > 7'h3C || (code > 7'h38 && code < 7'h3C);
   logic [7:0] wd_q;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wd_q <= 8'h00;
      end else begin
         wd_q <= cmd_wdata;
      end
   end
   AST_RD_ANSWER: assert property (rd_cmd |=> rd_valid)
      else $error("read not answered");
   AST_RD_NONE: assert property (!rd_cmd |=> !rd_valid)
      else $error("answer without read");
   AST_RD_IDLE: assert property (!rd_valid |-> rd_data == 8'h00)
      else $error("read data outside answer");
   AST_UNMAPPED: assert property (rd_cmd && unmapped |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   AST_TONE: assert property (wr_cmd && code == 7'h33 |=>
      teletax_freq_bit == wd_q[5] && tone_invert == wd_q[6]) else $error("tone bits wrong");
   AST_SENDER: assert property (wr_cmd && code == 7'h38 |=>
      sender_channel_pick == wd_q[6:4] && signalling_variant == wd_q[2])
      else $error("sender fields wrong");
   AST_LOOP: assert property (wr_cmd && code == 7'h3C |=>
      loopback_select == wd_q[4:0] && synth_power_down == wd_q[6]) else $error("loop bits wrong");
   AST_STROBE: assert property (send_bit_strobe |=> !send_bit_strobe)
      else $error("bit strobe too long");
endmodule : mfl_regs_chk
bind mfl_regs mfl_regs_chk chk_u (.core_clk, .rstn, .cmd_valid, .cmd_byte, .cmd_wdata,
   .rd_data, .rd_valid, .send_bit_strobe, .sender_channel_pick, .signalling_variant,
   .teletax_freq_bit, .tone_invert, .loopback_select, .synth_power_down);
`default_nettype wire

/* File: tb/mfl_host_src.sv */
// message byte source feeding the sender buffer
`timescale 1ns/10ps
`default_nettype none
module mfl_host_src (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // message stream
   input wire logic msg_ready,
   output logic msg_valid,
   output logic [7:0] msg_data
);
   logic [7:0] q[$];
   integer seed = 32'hb545;
   // holds a byte until taken, stalls at random, shows junk when idle
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         msg_valid <= 1'b0;
         msg_data <= 8'hA5;
      end else if (msg_valid && msg_ready) begin
         msg_valid <= 1'b0;
         msg_data <= ~msg_data;
      end else if (!msg_valid && q.size() > 0 && $random(seed) & 1) begin
         msg_valid <= 1'b1;
         msg_data <= q.pop_front();
      end else if (!msg_valid) begin
         msg_data <= ~msg_data;
      end
   end
endmodule : mfl_host_src
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench of the global command register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic cmd_valid;
   logic [7:0] cmd_byte;
   logic [7:0] cmd_wdata;
   logic [127:0] pcm_linear;
   logic [63:0] pcm_comp;
   wire logic [7:0] rd_data, msg_data;
   wire logic rd_valid, msg_valid, msg_ready, send_bit, send_bit_strobe, send_mute;
   wire logic signalling_variant, teletax_freq_bit, tone_invert, synth_power_down;
   wire logic [2:0] sender_channel_pick;
   wire logic [4:0] loopback_select;
   integer seed = 32'hb545;
   integer miscompares = 0;
   integer comparisons = 0;
   integer cyc = 0;
   logic saw_full = 1'b0;
   logic [7:0] mdl [0:127];
   logic exp_q[$];
   always #4 core_clk = ~core_clk;
   mfl_regs #(.FRAME_CYCLES(8), .BIT_CYCLES(4)) dut_u (.core_clk(core_clk), .rstn(rstn),
      .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
      .rd_valid(rd_valid), .pcm_linear(pcm_linear), .pcm_comp(pcm_comp),
      .msg_valid(msg_valid), .msg_data(msg_data), .msg_ready(msg_ready),
      .send_bit(send_bit), .send_bit_strobe(send_bit_strobe), .send_mute(send_mute),
      .sender_channel_pick(sender_channel_pick), .signalling_variant(signalling_variant),
      .teletax_freq_bit(teletax_freq_bit), .tone_invert(tone_invert),
      .loopback_select(loopback_select), .synth_power_down(synth_power_down));
   mfl_host_src host_u (.core_clk(core_clk), .rstn(rstn), .msg_ready(msg_ready),
      .msg_valid(msg_valid), .msg_data(msg_data));
   task automatic report_and_stop;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [7:0] msk(input logic [6:0] c);
      case (c)
         mfl_pkg::REG_METER_SEL: msk = mfl_pkg::MSEL_MASK;
         mfl_pkg::REG_SEND_CTRL: msk = mfl_pkg::SCTL_MASK;
         mfl_pkg::REG_LOOP_PD: msk = mfl_pkg::LOOP_MASK;
         7'h32, 7'h34, 7'h35, 7'h36, 7'h37: msk = 8'hFF;
         default: msk = 8'h00;
      endcase
   endfunction : msk
   task automatic cmd(input logic [7:0] b, input logic [7:0] d);
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_byte <= b;
      cmd_wdata <= d;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
   endtask : cmd
   task automatic wr(input logic [6:0] c, input logic [7:0] d);
      cmd({1'b0, c}, d);
      mdl[c] = d & msk(c);
   endtask : wr
   task automatic rd(input logic [6:0] c, output logic [7:0] v);
      cmd({1'b1, c}, 8'h00);
      #1;
      v = rd_data;
   endtask : rd
   task automatic check_all;
      logic [7:0] v;
      for (int c = 'h30; c <= 'h3D; c++) begin
         rd(c[6:0], v);
         chk(v, mdl[c]);
      end
   endtask : check_all
   task automatic wait_strobe;
      for (int i = 0; i < 50; i++) begin
         @(posedge core_clk);
         #1;
         if (send_bit_strobe === 1'b1) break;
      end
   endtask : wait_strobe
   task automatic run_send(input int sl, input int ml, input int wl, input int fl, input int mark_after_message);
      logic [7:0] b, v;
      int n;
      n = wl > 64 ? 64 : wl;
      exp_q = {};
      repeat (2 * sl) exp_q.push_back(exp_q.size() % 2 == 1);
      repeat (ml) exp_q.push_back(1'b1);
      for (int i = 0; i < n; i++) begin
         b = 8'($random(seed));
         host_u.q.push_back(b);
         if (i > 0) repeat (fl) exp_q.push_back(1'b1);
         exp_q.push_back(1'b0);
         for (int k = 0; k < 8; k++) exp_q.push_back(b[k]);
         exp_q.push_back(1'b1);
      end
      wr(7'h34, 8'(fl));
      wr(7'h35, 8'(wl));
      wr(7'h36, 8'(sl));
      wr(7'h37, 8'(ml));
      b = 8'h81 | (8'($random(seed)) & 8'h74) | 8'(mark_after_message << 1);
      wr(7'h38, b);
      foreach (exp_q[i]) begin
         wait_strobe();
         chk(send_bit, exp_q[i]);
      end
      if (mark_after_message != 0) begin
         repeat (4) begin
            wait_strobe();
            chk(send_bit, 1'b1);
         end
         chk(send_mute, 1'b0);
         wr(7'h38, b & 8'hFC);
      end
      for (int i = 0; i < 20 && send_mute !== 1'b1; i++) begin
         @(posedge core_clk);
         #1;
      end
      chk(send_mute, 1'b1);
      rd(7'h38, v);
      chk(v[0], 1'b0);
   endtask : run_send
   always @(posedge core_clk) begin
      if (msg_ready === 1'b0) saw_full <= 1'b1;
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      logic [7:0] v, d;
      logic [15:0] lin, mag;
      for (int c = 0; c < 128; c++) mdl[c] = 8'h00;
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
      cmd_wdata <= 8'h00;
      pcm_linear <= {4{$random(seed)}};
      pcm_comp <= {2{$random(seed)}};
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      check_all();
      for (int c = 'h30; c <= 'h3D; c++) begin
         d = 8'($random(seed));
         d = c == 'h33 ? d & 8'hEF : (c == 'h38 ? d & 8'h7E : d);
         wr(c[6:0], d);
      end
      check_all();
      chk(loopback_select, mdl[7'h3C][4:0]);
      chk(synth_power_down, mdl[7'h3C][6]);
      for (int ch = 0; ch < 8; ch++) begin
         @(posedge core_clk);
         pcm_comp <= {$random(seed), $random(seed)};
         wr(7'h33, 8'h10 | 8'(ch));
         repeat (20) @(posedge core_clk);
         rd(7'h31, v);
         chk(v, pcm_comp[ch * 8 +: 8]);
      end
      for (int w = 0; w < 2; w++) begin
         @(posedge core_clk);
         lin = 16'($random(seed)) | 16'h8000;
         pcm_linear <= {8{lin}};
         wr(7'h32, 8'(w * 3));
         wr(7'h33, 8'h18 | 8'(w * 5));
         repeat (60) @(posedge core_clk);
         mag = w == 0 ? lin : 16'(-lin);
         rd(7'h30, v);
         chk(v, {mag[7:1], 1'b1});
         rd(7'h31, v);
         chk(v, mag[15:8]);
      end
      wr(7'h33, 8'h08);
      rd(7'h31, v);
      chk(v, mag[15:8]);
      rd(7'h30, v);
      chk(v[0], 1'b0);
      run_send(1, 2, 2, 1, 0);
      run_send(0, 0, 100, 0, 0);
      chk(saw_full, 1'b1);
      chk(msg_ready, 1'b1);
      run_send(0, 1, 0, 0, 1);
      run_send(0, 0, 0, 0, 0);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
